/* csc_defs.svh */
// Constants for the command source combiner: selector codes, profile code, reset values.
// Assumes inclusion by csc_pkg.sv and the design files; holds definitions only.
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH

`define CSC_SEL_TERM 2'h0
`define CSC_SEL_BUS 2'h1
`define CSC_SEL_AND 2'h2
`define CSC_SEL_OR 2'h3
`define CSC_SEL_RESET 2'h3
`define CSC_PROF_NATIVE 2'h1
`define CSC_CMD_RESET 1'h0
`define CSC_BRAKE_RESET 1'h0
`define CSC_SETUP_RESET 3'h1
`define CSC_PRESET_RESET 2'h0
`define CSC_SETUP_SEL_RESET 2'h0
`define CSC_PRESET_GATED 2'h0
`define CSC_SETUP_OFFSET 3'h1

`endif

/* csc_pkg.sv */
// Types for the command source combiner.
// Assumes csc_defs.svh is on the include path.
`include "csc_defs.svh"
package csc_pkg;
	typedef logic [1:0] csc_sel_t;
	typedef struct packed {
		csc_sel_t brake;
		csc_sel_t start;
		csc_sel_t reverse;
		csc_sel_t setup;
		csc_sel_t preset;
	} csc_cfg_t;
	typedef struct packed {
		logic brake_n;
		logic start;
		logic reverse;
		logic [1:0] setup;
		logic [1:0] preset;
	} csc_cmd_t;
endpackage

/* csc_mux.sv */
// One terminal/bus combiner with a registered output.
// Assumes synchronous reset in the core clock domain.
`timescale 1ns/1ps
`include "csc_defs.svh"
module csc_mux #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [1:0] i_sel,
	input wire logic [W-1:0] i_term,
	input wire logic [W-1:0] i_bus,
	output logic [W-1:0] o_val
);
	logic [W-1:0] val_d;

	always_comb begin
		unique case (i_sel)
			`CSC_SEL_TERM: val_d = i_term;
			`CSC_SEL_BUS: val_d = i_bus;
			`CSC_SEL_AND: val_d = i_term & i_bus;
			`CSC_SEL_OR: val_d = i_term | i_bus;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_val <= RST;
		end else begin
			o_val <= val_d;
		end
	end
endmodule

/* csc_top.sv */
// Command source combiner: merges terminal and bus commands per two-bit selector.
// Assumes terminal and control-word bits are already synchronous to i_core_clk.
`timescale 1ns/1ps
`include "csc_defs.svh"
module csc_top (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// Configuration
	input wire csc_pkg::csc_cfg_t i_cfg,
	input wire logic i_cfg_load,
	input wire logic [1:0] i_telegram_profile,
	// Command sources
	input wire csc_pkg::csc_cmd_t i_term,
	input wire csc_pkg::csc_cmd_t i_bus,
	// Combined commands and selector readback
	output logic o_dc_brake,
	output logic o_start,
	output logic o_anticlockwise,
	output logic [2:0] o_active_setup,
	output logic [1:0] o_preset_sel,
	output csc_pkg::csc_cfg_t o_cfg
);
	import csc_pkg::*;

	// Selector registers, one per command, and their next values.
	csc_sel_t sel_brake_q;
	csc_sel_t sel_brake_d;
	csc_sel_t sel_start_q;
	csc_sel_t sel_start_d;
	csc_sel_t sel_rev_q;
	csc_sel_t sel_rev_d;
	csc_sel_t sel_setup_q;
	csc_sel_t sel_setup_d;
	csc_sel_t sel_preset_q;
	csc_sel_t sel_preset_d;

	// Active-high request levels and the profile-gated bus preset pair.
	logic term_brake;
	logic bus_brake;
	logic [1:0] bus_preset;

	// Combined setup value and its one-based form.
	logic [1:0] setup_q;
	logic [2:0] setup_d;

	// Every field takes its new code on the one load strobe, so a half-written set
	// never steers the outputs. The load is a data select, not a clock enable.
	always_comb begin
		sel_brake_d = sel_brake_q;
		if (i_cfg_load) begin
			sel_brake_d = i_cfg.brake;
		end
	end

	always_comb begin
		sel_start_d = sel_start_q;
		if (i_cfg_load) begin
			sel_start_d = i_cfg.start;
		end
	end

	always_comb begin
		sel_rev_d = sel_rev_q;
		if (i_cfg_load) begin
			sel_rev_d = i_cfg.reverse;
		end
	end

	always_comb begin
		sel_setup_d = sel_setup_q;
		if (i_cfg_load) begin
			sel_setup_d = i_cfg.setup;
		end
	end

	always_comb begin
		sel_preset_d = sel_preset_q;
		if (i_cfg_load) begin
			sel_preset_d = i_cfg.preset;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			sel_brake_q <= `CSC_SEL_RESET;
		end else begin
			sel_brake_q <= sel_brake_d;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			sel_start_q <= `CSC_SEL_RESET;
		end else begin
			sel_start_q <= sel_start_d;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			sel_rev_q <= `CSC_SEL_RESET;
		end else begin
			sel_rev_q <= sel_rev_d;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			sel_setup_q <= `CSC_SEL_RESET;
		end else begin
			sel_setup_q <= sel_setup_d;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			sel_preset_q <= `CSC_SEL_RESET;
		end else begin
			sel_preset_q <= sel_preset_d;
		end
	end

	// The selector readback trails the live selectors by one clock.
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_cfg <= {5{`CSC_SEL_RESET}};
		end else begin
			o_cfg.brake <= sel_brake_q;
			o_cfg.start <= sel_start_q;
			o_cfg.reverse <= sel_rev_q;
			o_cfg.setup <= sel_setup_q;
			o_cfg.preset <= sel_preset_q;
		end
	end

	// The brake pin and the brake control bit are active low. Inverting them here lets
	// the shared combiner work on the braking request itself, so AND brakes only when
	// both sources ask and OR brakes as soon as either one asks.
	assign term_brake = ~i_term.brake_n;
	assign bus_brake = ~i_bus.brake_n;

	// Outside the native profile the bus pair reads as zero: OR then falls back to the
	// terminal pair and AND yields preset zero.
	always_comb begin
		if (i_telegram_profile == `CSC_PROF_NATIVE) begin
			bus_preset = i_bus.preset;
		end else begin
			bus_preset = `CSC_PRESET_GATED;
		end
	end

	csc_mux #(
		.W(1),
		.RST(`CSC_BRAKE_RESET)
	) u_brake (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_sel(sel_brake_q),
		.i_term(term_brake),
		.i_bus(bus_brake),
		.o_val(o_dc_brake)
	);

	csc_mux #(
		.W(1),
		.RST(`CSC_CMD_RESET)
	) u_start (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_sel(sel_start_q),
		.i_term(i_term.start),
		.i_bus(i_bus.start),
		.o_val(o_start)
	);

	csc_mux #(
		.W(1),
		.RST(`CSC_CMD_RESET)
	) u_rev (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_sel(sel_rev_q),
		.i_term(i_term.reverse),
		.i_bus(i_bus.reverse),
		.o_val(o_anticlockwise)
	);

	csc_mux #(
		.W(2),
		.RST(`CSC_SETUP_SEL_RESET)
	) u_setup (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_sel(sel_setup_q),
		.i_term(i_term.setup),
		.i_bus(i_bus.setup),
		.o_val(setup_q)
	);

	csc_mux #(
		.W(2),
		.RST(`CSC_PRESET_RESET)
	) u_preset (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_sel(sel_preset_q),
		.i_term(i_term.preset),
		.i_bus(bus_preset),
		.o_val(o_preset_sel)
	);

	// The setup number is one-based to match the operator's view of setups 1 to 4; the
	// extra register costs one clock of latency on this output only.
	always_comb begin
		setup_d = {1'b0, setup_q} + `CSC_SETUP_OFFSET;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_active_setup <= `CSC_SETUP_RESET;
		end else begin
			o_active_setup <= setup_d;
		end
	end
endmodule

/* csc_mix.svh */
// Reference selector combiner for checks.
// Included inside a module body.
function automatic logic [1:0] mx(logic [1:0] s, logic [1:0] t, logic [1:0] b);
	return s == 2'h0 ? t : s == 2'h1 ? b : s == 2'h2 ? t & b : t | b;
endfunction

/* csc_top_assertions.sv */
// Port checker for csc_top.
// Bound onto csc_top.
`timescale 1ns/1ps
module csc_top_assertions (
	// Inputs
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire csc_pkg::csc_cfg_t i_cfg,
	input wire logic i_cfg_load,
	input wire logic [1:0] i_telegram_profile,
	input wire csc_pkg::csc_cmd_t i_term,
	input wire csc_pkg::csc_cmd_t i_bus,
	// Outputs
	input wire logic o_dc_brake,
	input wire logic o_start,
	input wire logic o_anticlockwise,
	input wire logic [2:0] o_active_setup,
	input wire logic [1:0] o_preset_sel,
	input wire csc_pkg::csc_cfg_t o_cfg
);
	import csc_pkg::*;
	`include "csc_mix.svh"
	csc_cfg_t s_q;
	csc_cmd_t t_q, b_q;
	logic [1:0] c_q;
	logic n_q;
	// Wait three load-free edges, so o_cfg is surely the live selector.
	always_ff @(posedge i_core_clk) begin
		c_q <= (i_rst || i_cfg_load) ? 2'h0 : c_q + {1'b0, c_q != 2'h3};
		s_q <= o_cfg;
		t_q <= i_term;
		b_q <= i_bus;
		n_q <= i_telegram_profile == 2'h1;
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	brake_mix_a: assert property (c_q == 2'h3 |=>
		{1'b0, o_dc_brake} == mx(s_q.brake, !t_q.brake_n, !b_q.brake_n)) else $error("brake");
	start_mix_a: assert property (c_q == 2'h3 |=>
		{1'b0, o_start} == mx(s_q.start, t_q.start, b_q.start)) else $error("start");
	reverse_mix_a: assert property (c_q == 2'h3 |=>
		{1'b0, o_anticlockwise} == mx(s_q.reverse, t_q.reverse, b_q.reverse)) else $error("rev");
	setup_plus_a: assert property (c_q == 2'h3 ##1 !i_cfg_load |=>
		o_active_setup == $past(mx(s_q.setup, t_q.setup, b_q.setup)) + 3'h1) else $error("setup");
	preset_mix_a: assert property (c_q == 2'h3 |=>
		o_preset_sel == mx(s_q.preset, t_q.preset, n_q ? b_q.preset : 2'h0)) else $error("preset");
	bus_only_a: assert property (c_q == 2'h3 && o_cfg.reverse == 2'h1 &&
		$stable(i_bus.reverse) |=> $stable(o_anticlockwise)) else $error("bus only");
	reset_sel_a: assert property ($fell(i_rst) |-> o_cfg == 10'h3FF) else $error("rst");
	cfg_load_a: assert property (i_cfg_load ##1 !i_cfg_load ##1 !i_cfg_load |->
		o_cfg == $past(i_cfg, 2)) else $error("cfg");
endmodule
bind csc_top csc_top_assertions u_csc_top_assertions (.*);

/* csc_bus_master.sv */
// Serial bus master model presenting received control words.
// The bench hands it the next word between edges.
`timescale 1ns/1ps
module csc_bus_master (
	// Clock and word
	input wire logic i_core_clk,
	input wire csc_pkg::csc_cmd_t i_word,
	// Bus
	output csc_pkg::csc_cmd_t o_bus
);
	import csc_pkg::*;
	always_ff @(posedge i_core_clk) begin
		o_bus <= i_word;
	end
endmodule

/* csc_top_tb.sv */
// Random bench for csc_top.
// Needs the package, bus model and checker compiled first.
`timescale 1ns/1ps
module csc_top_tb;
	import csc_pkg::*;
	`include "csc_mix.svh"
	logic clk = 1'b0, rst = 1'b1, ld = 1'b0, brk, st, ac;
	logic [1:0] prof = 2'h1, pre;
	logic [2:0] stp;
	logic [31:0] rnd = 32'hBE6E;
	csc_cfg_t cfg = '1, ocfg;
	csc_cmd_t trm = '0, word = '0, bus;
	int err_total = 0, samples_checked = 0;
	always #25 clk = ~clk;
	csc_bus_master u_csc_bus_master (.i_core_clk(clk), .i_word(word), .o_bus(bus));
	csc_top u_csc_top (.i_core_clk(clk), .i_rst(rst), .i_cfg(cfg), .i_cfg_load(ld),
		.i_telegram_profile(prof), .i_term(trm), .i_bus(bus), .o_dc_brake(brk), .o_start(st),
		.o_anticlockwise(ac), .o_active_setup(stp), .o_preset_sel(pre), .o_cfg(ocfg));
	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic cmp(logic [9:0] got, logic [9:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checked %0d failed %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic check_all;
		cmp(brk, mx(cfg.brake, !trm.brake_n, !word.brake_n));
		cmp(st, mx(cfg.start, trm.start, word.start));
		cmp(ac, mx(cfg.reverse, trm.reverse, word.reverse));
		cmp(stp, mx(cfg.setup, trm.setup, word.setup) + 3'h1);
		cmp(pre, mx(cfg.preset, trm.preset, prof == 2'h1 ? word.preset : 2'h0));
		cmp(ocfg, cfg);
	endtask
	task automatic check_reset;
		cmp(brk, 1'b0);
		cmp(st, 1'b0);
		cmp(ac, 1'b0);
		cmp(stp, 3'h1);
		cmp(pre, 2'h0);
		cmp(ocfg, 10'h3FF);
		cmp(ocfg.start, 2'h3);
	endtask
	initial begin
		#60000;
		err_total++;
		print_verdict();
	end
	initial begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		check_reset();
		for (int i = 0; i < 48; i++) begin
			rnd = lfsr(rnd);
			cfg = i < 4 ? {5{i[1:0]}} : rnd[9:0];
			prof = i[3] ? rnd[11:10] : 2'h1;
			ld = 1'b1;
			@(negedge clk);
			ld = 1'b0;
			rnd = lfsr(rnd);
			{trm, word} = i[2] ? 14'h0 : rnd[13:0];
			repeat (4) @(negedge clk);
			check_all();
			// Only the terminal moves now, so bus-only fields must hold their value.
			rnd = lfsr(rnd);
			trm = rnd[6:0];
			repeat (3) @(negedge clk);
			check_all();
			$display("test %0d", i);
		end
		// A reset in mid-run must drop the command outputs, return the active setup to 1 and bring all selectors back to OR.
		rst = 1'b1;
		repeat (2) @(negedge clk);
		check_reset();
		rst = 1'b0;
		cfg = '1;
		repeat (3) @(negedge clk);
		check_all();
		$display("test reset");
		print_verdict();
	end
endmodule
